// [verilog/idts_pkg.sv]
// Constants, reset values and state codes of the dual-port transfer sequencer.
package idts_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int WORD_W  = 32;
  localparam int RAM_AW  = 8;
  localparam int BYTE_AW = 10;
  localparam int CNT_W   = 16;
  localparam int BIT_W   = 6;

  // ---------------------------------------------------------------
  // Offsets and counts
  // ---------------------------------------------------------------
  localparam logic [BYTE_AW-1:0] SLOT_BYTES  = 10'h004;
  localparam int                 SLOT_LSB    = 2;
  localparam logic [BIT_W-1:0]   BITS_PER_CH = 6'h20;
  localparam logic [BIT_W-1:0]   FIRST_BIT   = 6'h01;
  localparam logic [BIT_W-1:0]   BIT_STEP    = 6'h01;
  localparam logic [CNT_W-1:0]   CNT_ONE     = 16'h0001;
  localparam int                 PORT_L      = 0;
  localparam int                 PORT_R      = 1;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [WORD_W-1:0]  WORD_RST  = 32'h0000_0000;
  localparam logic [BYTE_AW-1:0] ADDR_RST  = 10'h000;
  localparam logic [CNT_W-1:0]   CNT_RST   = 16'h0000;
  localparam logic [BIT_W-1:0]   BITS_RST  = 6'h00;
  localparam logic [1:0]         PAIR_RST  = 2'h0;
  localparam logic [1:0]         PAIR_ALL  = 2'h3;
  localparam logic [3:0]         CFG_RST   = 4'h0;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_DIS  = 8'h02,
    ST_ENA  = 8'h04,
    ST_XFER = 8'h08,
    ST_TADR = 8'h10,
    ST_ENDC = 8'h20,
    ST_RXW  = 8'h40,
    ST_RXA  = 8'h80
  } idts_state_t;

endpackage

// [verilog/idts_ram.sv]
// Dual-port audio word memory with registered read data.
`timescale 1ns/100ps
`default_nettype none
module idts_ram (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // Sequencer port
  input  wire logic                        a_we,
  input  wire logic [idts_pkg::RAM_AW-1:0] a_addr,
  input  wire logic [idts_pkg::WORD_W-1:0] a_wdata,
  output var  logic [idts_pkg::WORD_W-1:0] a_rdata,
  // User port
  input  wire logic                        b_we,
  input  wire logic [idts_pkg::RAM_AW-1:0] b_addr,
  input  wire logic [idts_pkg::WORD_W-1:0] b_wdata,
  output var  logic [idts_pkg::WORD_W-1:0] b_rdata
);
  import idts_pkg::*;

  logic [WORD_W-1:0] mem [0:(1<<RAM_AW)-1];

  // The sequencer port wins when both ports write one word together.
  always_ff @(posedge clk)
  begin
    if (b_we && !(a_we && a_addr == b_addr))
      mem[b_addr] <= b_wdata;
    if (a_we)
      mem[a_addr] <= a_wdata;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      a_rdata <= WORD_RST;
      b_rdata <= WORD_RST;
    end
    else
    begin
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
    end
  end

endmodule
`default_nettype wire

// [verilog/idts_top.sv]
// Stereo serial transfer sequencer: two slave ports and a chained mover.
//
// Behaviour
// - Left and right words alternate in memory, one 4-byte slot each.
// - Running source address passes from left transfer to right and back.
// - Left transmit activation: disable, enable port, move word, pass address.
// - Streams end when chains disable ports themselves, no software write.
// - End chain is followed only when the entry counter reaches zero.
// - Left counter loads n-1; activation n only disables the left port.
// - Right counter loads n; activation n+1 only disables the right port.
// - Each port is a slave shifting 32-bit words MSB first both ways.
// - Data input feeds both ports; left selects on low, right on high.
// - Receive samples first bit on first rising clock after a switch.
// - Slave select lags word select by about one bit clock.
// - Receive-full of each port triggers that port's receive transfer.
// - Left port re-initialised on select rise, right port on select fall.
// - Receive chain stores word, passes destination address, returns to idle.
// - Re-initialising writes enable bit to 0 and then back to 1.
// - Word select low carries left sample, high carries right sample.
// - Transmit drives first bit on first falling clock after a switch.
// - Left transmit on select rise, right transmit on select fall.
// - The port not transmitting floats its output.
`timescale 1ns/100ps
`default_nettype none
module idts_top (
  // System clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset,
  // Link pins
  input  wire logic                         sck,
  input  wire logic                         channel_slave_select_line,
  input  wire logic                         ws,
  input  wire logic                         sdi,
  output var  logic                         sdo_left,
  output var  logic                         sdo_left_oe_n,
  output var  logic                         sdo_right,
  output var  logic                         sdo_right_oe_n,
  // Control
  input  wire logic                         start,
  input  wire logic                         tx_on,
  input  wire logic                         rx_on,
  input  wire logic [idts_pkg::CNT_W-1:0]   word_count,
  input  wire logic [idts_pkg::BYTE_AW-1:0] tx_base,
  input  wire logic [idts_pkg::BYTE_AW-1:0] rx_base,
  // Status
  output var  logic                         busy,
  output var  logic                         done,
  output var  logic [1:0]                   port_function_enable_bit,
  output var  logic [idts_pkg::BYTE_AW-1:0] tx_addr_now,
  output var  logic [idts_pkg::BYTE_AW-1:0] rx_addr_now,
  output var  logic                         align_err,
  // User memory port
  input  wire logic                         ram_we,
  input  wire logic [idts_pkg::RAM_AW-1:0]  ram_addr,
  input  wire logic [idts_pkg::WORD_W-1:0]  ram_wdata,
  output var  logic [idts_pkg::WORD_W-1:0]  ram_rdata
);
  import idts_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [BYTE_AW-1:0] next_addr(
    input logic [BYTE_AW-1:0] addr);
    next_addr = addr + SLOT_BYTES;
  endfunction

  function automatic logic [1:0] port_mask(input logic p);
    port_mask = p ? 2'h2 : 2'h1;
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  idts_state_t             state_q;
  idts_state_t             state_d;
  logic                    port_q;
  logic                    port_d;
  logic [1:0]              en_q;
  logic [1:0]              en_d;
  logic [1:0]              ri_tgl_q;
  logic [1:0]              ri_tgl_d;
  logic [1:0]              chain_q;
  logic [1:0]              chain_d;
  logic [1:0]              run_q;
  logic [1:0]              run_d;
  logic [1:0][CNT_W-1:0]   cnt_q;
  logic [1:0][CNT_W-1:0]   cnt_d;
  logic [BYTE_AW-1:0]      tx_addr_q;
  logic [BYTE_AW-1:0]      tx_addr_d;
  logic [BYTE_AW-1:0]      rx_addr_q;
  logic [BYTE_AW-1:0]      rx_addr_d;
  logic [1:0][WORD_W-1:0]  tx_word_q;
  logic [1:0][WORD_W-1:0]  tx_word_d;
  logic                    tx_mode_q;
  logic                    rx_mode_q;
  logic                    busy_q;
  logic                    done_q;
  logic [1:0]              act_pend_q;
  logic [1:0]              rx_pend_q;
  logic                    ssl_s1_q;
  logic                    ssl_s2_q;
  logic                    ssl_s3_q;
  logic [1:0]              rxt_s1_q;
  logic [1:0]              rxt_s2_q;
  logic [1:0]              rxt_s3_q;
  logic [WORD_W-1:0]       ram_a_rdata;
  // Link domain
  logic                    ssl_q;
  logic                    ssl_nq;
  logic [3:0]              cfg_s1_q;
  logic [3:0]              cfg_s2_q;
  logic [1:0]              ri_s1_q;
  logic [1:0]              ri_s2_q;
  logic [1:0]              ri_s3_q;
  logic [WORD_W-1:0]       rx_sh_q;
  logic [BIT_W-1:0]        rx_cnt_q;
  logic [BIT_W-1:0]        rx_cnt_d;
  logic [1:0][WORD_W-1:0]  rx_hold_q;
  logic [1:0]              rxt_q;
  logic                    align_err_q;
  logic [WORD_W-1:0]       tx_sh_q;
  logic [1:0]              sdo_q;
  logic [1:0]              oe_n_q;

  // ---------------------------------------------------------------
  // Event capture in the system domain
  // ---------------------------------------------------------------
  wire       ssl_rise  = ssl_s2_q & ~ssl_s3_q;
  wire       ssl_fall  = ~ssl_s2_q & ssl_s3_q;
  wire [1:0] act_evt   = {ssl_fall, ssl_rise} & run_q;
  wire [1:0] rx_evt    = (rxt_s2_q ^ rxt_s3_q) & run_q & {2{rx_mode_q}};
  wire       st_idle   = (state_q == ST_IDLE);
  wire       take_act  = st_idle & (|act_pend_q);
  wire       take_rx   = st_idle & ~(|act_pend_q) & (|rx_pend_q);
  wire       act_port  = ~act_pend_q[PORT_L];
  wire       rx_port   = ~rx_pend_q[PORT_L];
  wire [1:0] clr_act   = take_act ? port_mask(act_port) : PAIR_RST;
  wire [1:0] clr_rx    = take_rx ? port_mask(rx_port) : PAIR_RST;
  wire       start_ok  = start & ~busy_q;
  wire       cnt_hit   = (cnt_q[port_q] == CNT_ONE);
  wire [CNT_W-1:0] cnt_dec = cnt_q[port_q] - CNT_ONE;

  // ---------------------------------------------------------------
  // Chain sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d   = state_q;
    port_d    = port_q;
    en_d      = en_q;
    ri_tgl_d  = ri_tgl_q;
    chain_d   = chain_q;
    run_d     = run_q;
    cnt_d     = cnt_q;
    tx_addr_d = tx_addr_q;
    rx_addr_d = rx_addr_q;
    tx_word_d = tx_word_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (start_ok)
        begin
          cnt_d[PORT_L] = word_count - CNT_ONE;
          cnt_d[PORT_R] = word_count;
          chain_d       = PAIR_ALL;
          run_d         = PAIR_ALL;
          en_d          = PAIR_ALL;
          tx_addr_d     = tx_base;
          rx_addr_d     = rx_base;
        end
        else if (take_act)
        begin
          port_d  = act_port;
          state_d = ST_DIS;
        end
        else if (take_rx)
        begin
          port_d  = rx_port;
          state_d = ST_RXW;
        end
      end
      ST_DIS:
      begin
        en_d[port_q]     = 1'b0;
        ri_tgl_d[port_q] = ~ri_tgl_q[port_q];
        if (chain_q[port_q])
          state_d = ST_ENA;
        else
        begin
          run_d[port_q] = 1'b0;
          state_d       = ST_IDLE;
        end
      end
      ST_ENA:
      begin
        en_d[port_q] = 1'b1;
        if (tx_mode_q)
          state_d = ST_XFER;
        else
        begin
          cnt_d[port_q] = cnt_dec;
          state_d       = cnt_hit ? ST_ENDC : ST_IDLE;
        end
      end
      ST_XFER:
        state_d = ST_TADR;
      ST_TADR:
      begin
        tx_word_d[port_q] = ram_a_rdata;
        tx_addr_d         = next_addr(tx_addr_q);
        cnt_d[port_q]     = cnt_dec;
        state_d           = cnt_hit ? ST_ENDC : ST_IDLE;
      end
      ST_ENDC:
      begin
        chain_d[port_q] = 1'b0;
        state_d         = ST_IDLE;
      end
      ST_RXW:
        state_d = ST_RXA;
      ST_RXA:
      begin
        rx_addr_d = next_addr(rx_addr_q);
        state_d   = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q   <= ST_IDLE;
      port_q    <= 1'b0;
      en_q      <= PAIR_RST;
      ri_tgl_q  <= PAIR_RST;
      chain_q   <= PAIR_RST;
      run_q     <= PAIR_RST;
      cnt_q     <= {CNT_RST, CNT_RST};
      tx_addr_q <= ADDR_RST;
      rx_addr_q <= ADDR_RST;
      tx_word_q <= {WORD_RST, WORD_RST};
    end
    else
    begin
      state_q   <= state_d;
      port_q    <= port_d;
      en_q      <= en_d;
      ri_tgl_q  <= ri_tgl_d;
      chain_q   <= chain_d;
      run_q     <= run_d;
      cnt_q     <= cnt_d;
      tx_addr_q <= tx_addr_d;
      rx_addr_q <= rx_addr_d;
      tx_word_q <= tx_word_d;
    end
  end

  // ---------------------------------------------------------------
  // Pending activations, modes and status
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      act_pend_q <= PAIR_RST;
      rx_pend_q  <= PAIR_RST;
      tx_mode_q  <= 1'b0;
      rx_mode_q  <= 1'b0;
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      ssl_s1_q   <= 1'b1;
      ssl_s2_q   <= 1'b1;
      ssl_s3_q   <= 1'b1;
      rxt_s1_q   <= PAIR_RST;
      rxt_s2_q   <= PAIR_RST;
      rxt_s3_q   <= PAIR_RST;
    end
    else
    begin
      // A new event wins over the clear of the same cycle.
      act_pend_q <= (act_pend_q & ~clr_act) | act_evt;
      rx_pend_q  <= (rx_pend_q & ~clr_rx) | rx_evt;
      tx_mode_q  <= start_ok ? tx_on : tx_mode_q;
      rx_mode_q  <= start_ok ? rx_on : rx_mode_q;
      busy_q     <= |run_d;
      done_q     <= ~start_ok & (done_q | (busy_q & ~(|run_d)));
      ssl_s1_q   <= channel_slave_select_line;
      ssl_s2_q   <= ssl_s1_q;
      ssl_s3_q   <= ssl_s2_q;
      rxt_s1_q   <= rxt_q;
      rxt_s2_q   <= rxt_s1_q;
      rxt_s3_q   <= rxt_s2_q;
    end
  end

  // ---------------------------------------------------------------
  // Audio memory
  // ---------------------------------------------------------------
  // interleaved word slots
  wire [RAM_AW-1:0] seq_addr = (state_q == ST_RXW)
                             ? rx_addr_q[SLOT_LSB +: RAM_AW]
                             : tx_addr_q[SLOT_LSB +: RAM_AW];

  // Receive holding words are stable for a whole channel period.
  idts_ram u_ram (
    .clk     (clk),
    .reset   (reset),
    .a_we    (state_q == ST_RXW),
    .a_addr  (seq_addr),
    .a_wdata (rx_hold_q[port_q]),
    .a_rdata (ram_a_rdata),
    .b_we    (ram_we),
    .b_addr  (ram_addr),
    .b_wdata (ram_wdata),
    .b_rdata (ram_rdata)
  );

  // ---------------------------------------------------------------
  // Link receive side, rising bit clock
  // ---------------------------------------------------------------
  // select polarity per port
  wire       rx_p     = ssl_q;
  wire       chan_sw  = (channel_slave_select_line != ssl_q);
  wire [1:0] ri_evt   = ri_s2_q ^ ri_s3_q;
  wire       listen   = cfg_s2_q[channel_slave_select_line];
  wire       ri_hit   = ri_evt[channel_slave_select_line];
  wire [WORD_W-1:0] rx_sh_d = {rx_sh_q[WORD_W-2:0], sdi};
  wire       rx_done  = listen & (rx_cnt_d == BITS_PER_CH)
                      & (rx_cnt_q != BITS_PER_CH);

  always_comb
  begin
    rx_cnt_d = rx_cnt_q;
    if (chan_sw)
      rx_cnt_d = FIRST_BIT;
    else if (ri_hit)
      rx_cnt_d = BITS_RST;
    else if (listen && rx_cnt_q != BITS_PER_CH)
      rx_cnt_d = rx_cnt_q + BIT_STEP;
  end

  always_ff @(posedge sck or posedge reset)
  begin
    if (reset)
    begin
      ssl_q       <= 1'b1;
      cfg_s1_q    <= CFG_RST;
      cfg_s2_q    <= CFG_RST;
      ri_s1_q     <= PAIR_RST;
      ri_s2_q     <= PAIR_RST;
      ri_s3_q     <= PAIR_RST;
      rx_sh_q     <= WORD_RST;
      rx_cnt_q    <= BITS_RST;
      rx_hold_q   <= {WORD_RST, WORD_RST};
      rxt_q       <= PAIR_RST;
      align_err_q <= 1'b0;
    end
    else
    begin
      ssl_q    <= channel_slave_select_line;
      cfg_s1_q <= {en_q & {2{tx_mode_q}}, en_q & {2{rx_mode_q}}};
      cfg_s2_q <= cfg_s1_q;
      ri_s1_q  <= ri_tgl_q;
      ri_s2_q  <= ri_s1_q;
      ri_s3_q  <= ri_s2_q;
      rx_sh_q  <= rx_sh_d;
      rx_cnt_q <= rx_cnt_d;
      if (rx_done)
      begin
        rx_hold_q[channel_slave_select_line] <= rx_sh_d;
        rxt_q[channel_slave_select_line]     <= ~rxt_q[rx_p ^ chan_sw];
      end
      if (chan_sw && ws != channel_slave_select_line)
        align_err_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Link transmit side, falling bit clock
  // ---------------------------------------------------------------
  wire       tsw      = (ssl_q != ssl_nq);
  wire [WORD_W-1:0] tx_sh_d = tsw ? tx_word_q[ssl_q]
                                  : {tx_sh_q[WORD_W-2:0], 1'b0};
  wire [1:0] drive    = cfg_s2_q[3:2] & port_mask(ssl_q);

  always_ff @(negedge sck or posedge reset)
  begin
    if (reset)
    begin
      ssl_nq  <= 1'b1;
      tx_sh_q <= WORD_RST;
      sdo_q   <= PAIR_RST;
      oe_n_q  <= PAIR_ALL;
    end
    else
    begin
      ssl_nq  <= ssl_q;
      tx_sh_q <= tx_sh_d;
      sdo_q   <= drive & {2{tx_sh_d[WORD_W-1]}};
      oe_n_q  <= ~drive;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign sdo_left                 = sdo_q[PORT_L];
  assign sdo_left_oe_n            = oe_n_q[PORT_L];
  assign sdo_right                = sdo_q[PORT_R];
  assign sdo_right_oe_n           = oe_n_q[PORT_R];
  assign busy                     = busy_q;
  assign done                     = done_q;
  assign port_function_enable_bit = en_q;
  assign tx_addr_now              = tx_addr_q;
  assign rx_addr_now              = rx_addr_q;
  assign align_err                = align_err_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_REINIT_SEQ: assert property (@(posedge clk) disable iff (reset)
    (state_q == ST_DIS && chain_q[port_q]) |=>
      (state_q == ST_ENA && !en_q[port_q]) ##1 en_q[port_q])
    else $error("port not disabled then enabled");

  AST_ADDR_PASS: assert property (@(posedge clk) disable iff (reset)
    (state_q == ST_TADR) |=> tx_addr_q == $past(tx_addr_q) + SLOT_BYTES)
    else $error("source address not advanced by one slot");

  AST_TX_CHAIN: assert property (@(posedge clk) disable iff (reset)
    (state_q == ST_DIS && chain_q[port_q] && tx_mode_q) |=>
      state_q == ST_ENA ##1 state_q == ST_XFER ##1 state_q == ST_TADR)
    else $error("transmit chain out of order");

  AST_STOP: assert property (@(posedge clk) disable iff (reset)
    (state_q == ST_DIS && !chain_q[port_q]) |=>
      !run_q[$past(port_q)] && !en_q[$past(port_q)])
    else $error("final activation did not halt port");

  AST_END_AT_ZERO: assert property (@(posedge clk) disable iff (reset)
    (state_q == ST_TADR) |=> (state_q == ST_ENDC) == $past(cnt_hit))
    else $error("end chain taken without zero count");

  AST_LOAD: assert property (@(posedge clk) disable iff (reset)
    start_ok |=> cnt_q[PORT_L] == $past(word_count) - CNT_ONE
             && cnt_q[PORT_R] == $past(word_count))
    else $error("counters not loaded with n-1 and n");

  AST_END_CLEARS: assert property (@(posedge clk) disable iff (reset)
    (state_q == ST_ENDC) |=> !chain_q[$past(port_q)] && run_q[$past(port_q)])
    else $error("end chain did not clear chain enable");

  AST_RX_TRIG: assert property (@(posedge clk) disable iff (reset)
    rx_evt[PORT_R] |=> rx_pend_q[PORT_R] || state_q == ST_RXW)
    else $error("receive full event lost");

  AST_RX_CHAIN: assert property (@(posedge clk) disable iff (reset)
    (state_q == ST_RXW) |=> state_q == ST_RXA ##1
      rx_addr_q == $past(rx_addr_q, 2) + SLOT_BYTES)
    else $error("receive chain did not pass address");

  AST_EDGE_TRIG: assert property (@(posedge clk) disable iff (reset)
    act_evt[PORT_L] |=> act_pend_q[PORT_L])
    else $error("select rise did not request left activation");

  AST_FIRST_BIT: assert property (@(posedge sck) disable iff (reset)
    chan_sw |=> rx_cnt_q == FIRST_BIT)
    else $error("first bit not taken after switch");

  AST_ONE_DRIVER: assert property (@(negedge sck) disable iff (reset)
    !(!oe_n_q[PORT_L] && !oe_n_q[PORT_R]))
    else $error("both ports drive data");

  COV_END_CHAIN: cover property (@(posedge clk) disable iff (reset)
    state_q == ST_ENDC);
  COV_STOP: cover property (@(posedge clk) disable iff (reset)
    state_q == ST_DIS && !chain_q[port_q]);
  COV_RX_STORE: cover property (@(posedge clk) disable iff (reset)
    state_q == ST_RXW);
  COV_DONE: cover property (@(posedge clk) disable iff (reset)
    $rose(done_q));

endmodule
`default_nettype wire

// [testbench/idts_codec.sv]
// Stereo serial audio source driving the link pins.
`timescale 1ns/100ps
`default_nettype none
module idts_codec (
  // Control
  input  wire logic        en,
  input  wire logic [31:0] lw,
  input  wire logic [31:0] rw,
  // Link pins
  output var  logic        sck,
  output wire logic        ws,
  output wire logic        sel,
  output wire logic        sdi
);
  // Idle rests at the end of a right half: word and slave select both high.
  logic      [5:0] cnt = 6'h3f;
  wire logic [5:0] lag = cnt - 6'h01;
  initial
  begin
    sck = 1'b1;
    #7;
    forever #15 sck = ~sck;
  end
  always @(negedge sck)
    cnt <= en ? cnt + 6'h01 : 6'h3f;
  // word select, select one bit later
  assign ws  = cnt[5];
  assign sel = lag[5];
  assign sdi = sel ? rw[~lag[4:0]] : lw[~lag[4:0]];
endmodule
`default_nettype wire

// [testbench/idts_top_tb.sv]
// Self-checking bench of the stereo transfer sequencer.
`timescale 1ns/100ps
`default_nettype none
module idts_top_tb;
  import idts_pkg::*;
  logic        clk, reset, start, tx_on, rx_on, ram_we, en, busy, done;
  logic        sck, ws, sel, sdi, sl, sl_n, sr, sr_n, aerr;
  logic [1:0]  pe;
  logic [15:0] n;
  logic [9:0]  txb, rxb, ta, ra;
  logic [7:0]  a8;
  logic [31:0] wd, rd, lw, rw, rv;
  int          bad_count, samples_checked, i;
  idts_codec far (.en(en), .lw(lw), .rw(rw), .sck(sck), .ws(ws),
    .sel(sel), .sdi(sdi));
  idts_top uut (.clk(clk), .reset(reset), .sck(sck),
    .channel_slave_select_line(sel), .ws(ws), .sdi(sdi),
    .sdo_left(sl), .sdo_left_oe_n(sl_n), .sdo_right(sr),
    .sdo_right_oe_n(sr_n), .start(start), .tx_on(tx_on),
    .rx_on(rx_on), .word_count(n), .tx_base(txb), .rx_base(rxb),
    .busy(busy), .done(done), .port_function_enable_bit(pe),
    .tx_addr_now(ta), .rx_addr_now(ra), .align_err(aerr),
    .ram_we(ram_we), .ram_addr(a8), .ram_wdata(wd), .ram_rdata(rd));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Source address after n-1 left and n right word fetches.
  function automatic logic [31:0] tx_end(logic [15:0] c, logic [9:0] b);
    tx_end = (32'(c) * 32'h2 - 32'h1) * 32'(SLOT_BYTES) + 32'(b);
  endfunction
  task automatic rdm(logic [7:0] a, output logic [31:0] d);
    @(negedge clk) a8 = a;
    @(negedge clk) d = rd;
  endtask
  // Only one port may drive the shared line.
  always @(posedge sck)
    if (en)
      chk("one driver", 1, {31'h0, sl_n | sr_n});
  initial
  begin
    {reset, start, tx_on, rx_on, ram_we, en, a8, wd} = '0;
    {n, txb, rxb} = '0;
    reset = 1'b1;
    lw = $urandom(32'h889b8e17);
    rw = $urandom();
    repeat (10) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    for (i = 0; i < 8; i++)
    begin
      @(negedge clk) {ram_we, a8, wd} = {1'b1, i[7:0], $urandom()};
    end
    @(negedge clk) ram_we = 1'b0;
    {n, txb, rxb} = {16'h0002 + 16'($urandom_range(0, 2)), 10'h0, 10'h200};
    {start, tx_on, rx_on} = 3'h7;
    @(negedge clk) start = 1'b0;
    @(negedge clk) {start, rxb} = {1'b1, 10'h300};
    chk("busy", 1, {31'h0, busy});
    chk("enables", 3, {30'h0, pe});
    chk("tx address", 0, {22'h0, ta});
    @(negedge clk) start = 1'b0;
    @(negedge clk) en = 1'b1;
    chk("rx address", 10'h200, {22'h0, ra});
    for (i = 0; i < 5000 && done !== 1'b1; i++)
      @(negedge clk);
    chk("done", 1, {31'h0, done});
    if (i < 5000)
    begin
      chk("enables off", 0, {30'h0, pe});
      chk("busy off", 0, {31'h0, busy});
      chk("align", 0, {31'h0, aerr});
      chk("tx end address", tx_end(n, txb), {22'h0, ta});
      rdm(8'h80, rv);
      chk("left word", lw, rv);
      rdm(8'h81, rv);
      chk("right word", rw, rv);
      repeat (16) @(negedge clk);
      chk("ports floating", 3, {30'h0, sr_n, sl_n});
      chk("idle data", 0, {30'h0, sr, sl});
    end
    give_verdict();
  end
endmodule
`default_nettype wire
